// ==== cache_far_side.sv ====
// far side model: translation unit, tag arrays and memory bus
`default_nettype none
module ack_gen (
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire logic [3:0] lat,
   output logic ack_q
);
   logic [3:0] cnt_q;
   // one ack pulse lat+1 cycles after each request rises
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= req && !ack_q && cnt_q == lat;
         cnt_q <= (req && !ack_q && cnt_q != lat) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule : ack_gen
module cache_far_side (
   // clock, reset, answer delay
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] lat,
   // translation
   input wire logic mmu_req,
   input wire logic [31:0] vaddr,
   input wire logic miss_i,
   output logic mmu_ack,
   output logic [31:0] paddr,
   output logic miss,
   output logic inval,
   // tag arrays and memory
   input wire logic tag_req,
   input wire cache_op_pkg::tag_rsp_t rsp_i,
   output logic tag_ack,
   output cache_op_pkg::tag_rsp_t rsp,
   input wire logic mem_req,
   input wire logic err_i,
   output logic mem_ack,
   output logic err
);
   import cache_op_pkg::*;
   ack_gen i_mmu (.clk, .rst, .req(mmu_req), .lat, .ack_q(mmu_ack));
   ack_gen i_tag (.clk, .rst, .req(tag_req), .lat, .ack_q(tag_ack));
   ack_gen i_mem (.clk, .rst, .req(mem_req), .lat, .ack_q(mem_ack));
   // answers are inverted outside the ack cycle
   assign paddr = mmu_ack ? vaddr : ~vaddr;
   assign miss = mmu_ack ? miss_i : ~miss_i;
   assign inval = !mmu_ack;
   assign rsp = tag_ack ? rsp_i : ~rsp_i;
   assign err = mem_ack ? err_i : ~err_i;
endmodule : cache_far_side
`default_nettype wire

// ==== cache_maint_monitor.sv ====
// port assertions for the cache maintenance unit
`default_nettype none
module cache_maint_monitor (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   // issue
   input wire logic ISSUE_VALID,
   input wire logic COP0_USABLE,
   input wire logic ISSUE_READY,
   input wire logic DONE,
   input wire cache_op_pkg::exc_kind_t EXC_KIND,
   input wire logic EXC_LOAD_CAUSE,
   // far side and registers
   input wire logic MMU_REQ,
   input wire logic MMU_ACK,
   input wire logic TAG_REQ,
   input wire logic TAG_ACK,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA
);
   import cache_op_pkg::*;
   // **********
   // properties
   // **********
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SYS_RST);
   sequence s_take;
      CLK_EN && ISSUE_VALID && ISSUE_READY;
   endsequence
   sequence s_unusable;
      ##2 DONE && EXC_KIND == EXC_COP_UNUSABLE;
   endsequence
   a_cop_unusable: assert property
      (s_take ##0 !COP0_USABLE |-> s_unusable) else $error("no unusable");
   a_ready_drop: assert property
      (s_take |=> !ISSUE_READY) else $error("ready held after take");
   a_done_pulse: assert property
      (DONE && CLK_EN |=> !DONE) else $error("done too long");
   a_exc_quiet: assert property
      (!DONE |-> EXC_KIND == EXC_NONE) else $error("stray exception");
   a_load_cause: assert property
      (EXC_LOAD_CAUSE == (DONE && EXC_KIND inside
      {EXC_ADDR_LOAD, EXC_TLB_REFILL, EXC_TLB_INVALID}))
      else $error("load cause wrong");
   a_mmu_hold: assert property
      (MMU_REQ && !MMU_ACK |=> MMU_REQ) else $error("mmu request dropped");
   a_mmu_release: assert property
      (CLK_EN && MMU_REQ && MMU_ACK |=> !MMU_REQ) else $error("mmu held");
   a_tag_release: assert property
      (CLK_EN && TAG_REQ && TAG_ACK |=> !TAG_REQ) else $error("tag held");
   a_rdata_idle: assert property
      (CLK_EN && !REG_RD |=> REG_RDATA == 32'h0) else $error("rdata not 0");
endmodule : cache_maint_monitor
bind cache_maint_unit cache_maint_monitor i_mon (.SYS_CLK, .SYS_RST,
   .CLK_EN, .ISSUE_VALID, .COP0_USABLE, .ISSUE_READY, .DONE, .EXC_KIND,
   .EXC_LOAD_CAUSE, .MMU_REQ, .MMU_ACK, .TAG_REQ, .TAG_ACK, .REG_RD,
   .REG_RDATA);
`default_nettype wire

// ==== cache_maint_unit.sv ====
// cache maintenance instruction engine with holding registers
//
// The address map and the address-and-strobe port are this design's own decisions.
`default_nettype none
module cache_maint_unit #(
   parameter int WAY_SIZE_LOG2 = 13,
   parameter int ASSOC = 4,
   parameter int BPT_LOG2 = 5
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   // instruction issue
   input wire logic ISSUE_VALID,
   input wire logic [31:0] ISSUE_INSTR,
   input wire logic [31:0] ISSUE_BASE,
   input wire logic COP0_USABLE,
   input wire logic KERNEL_MODE,
   output logic ISSUE_READY,
   output logic DONE,
   output cache_op_pkg::exc_kind_t EXC_KIND,
   output logic EXC_LOAD_CAUSE,
   // address translation
   output logic MMU_REQ,
   output logic [31:0] MMU_VADDR,
   input wire logic MMU_ACK,
   input wire logic [31:0] MMU_PADDR,
   input wire logic MMU_MISS,
   input wire logic MMU_INVALID,
   // tag arrays
   output logic TAG_REQ,
   output cache_op_pkg::tag_req_t TAG_CMD,
   input wire logic TAG_ACK,
   input wire cache_op_pkg::tag_rsp_t TAG_RSP,
   // memory bus
   output logic MEM_REQ,
   output logic MEM_WR,
   output logic [31:0] MEM_ADDR,
   input wire logic MEM_ACK,
   input wire logic MEM_ERR,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA
);
   import cache_op_pkg::*;

   // ***************************************************
   // state and storage
   // ***************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_XLATE = 3'h1,
      ST_TAG = 3'h2,
      ST_WBACK = 3'h3,
      ST_FILL = 3'h4,
      ST_UPDATE = 3'h5,
      ST_FINISH = 3'h6
   } state_t;

   state_t state_q;
   cache_sel_t sel_q;
   cache_op_t op_q;
   logic [31:0] ea_q;
   logic [31:0] caddr_q;
   logic [3:0] way_q;
   logic [15:0] index_q;
   tag_entry_t new_q;
   logic fill_after_wb_q;
   exc_kind_t exc_q;
   logic [31:0] ctl_q;
   logic [31:0] tag_low_q;
   logic [31:0] tag_high_q;
   logic [31:0] data_low_q;
   logic [31:0] data_high_q;
   logic load_tag_done;

   // ***************************************************
   // decode of the incoming instruction
   // ***************************************************
   logic [31:0] ea_d;
   cache_sel_t sel_d;
   cache_op_t op_d;
   logic addr_op_d;
   logic virt_d;
   logic take;

   assign ea_d = ISSUE_BASE + {{16{ISSUE_INSTR[OFFSET_W-1]}},
                 ISSUE_INSTR[OFFSET_LSB +: OFFSET_W]};
   assign sel_d = cache_sel_t'(ISSUE_INSTR[SEL_LSB +: 2]);
   assign op_d = cache_op_t'(ISSUE_INSTR[OP_LSB +: 3]);
   assign addr_op_d = op_d[2];
   assign virt_d = ctl_q[CTL_VIRT_LSB + 32'(sel_d)];
   assign take = CLK_EN && ISSUE_VALID && ISSUE_READY;

   // way and set fields of an address for index operations
   function automatic logic [3:0] way_of(input logic [31:0] a);
      logic [31:0] w;
      w = a >> WAY_SIZE_LOG2;
      if (ASSOC <= 1)
      begin
         way_of = 4'h0;
      end
      else
      begin
         way_of = 4'(w & 32'(ASSOC - 1));
      end
   endfunction : way_of

   function automatic logic [15:0] index_of(input logic [31:0] a);
      logic [31:0] m;
      m = (32'h1 << (WAY_SIZE_LOG2 - BPT_LOG2)) - 32'h1;
      index_of = 16'((a >> BPT_LOG2) & m);
   endfunction : index_of

   // ***************************************************
   // per-op view of the tag answer
   // ***************************************************
   logic dirty_line;
   logic hit;
   logic wb_go;
   logic [31:0] victim_addr;

   assign dirty_line = ctl_q[CTL_WBACK_LSB + 32'(sel_q)]
                       && TAG_RSP.entry.valid && TAG_RSP.entry.dirty;
   assign hit = TAG_RSP.hit;
   // the op must write the dirty victim back before it goes on
   assign wb_go = dirty_line && (op_q == OP_INDEX_INV
                  || (hit && (op_q == OP_HIT_WB_INV || op_q == OP_HIT_WB))
                  || (!hit && op_q == OP_FETCH_LOCK));
   assign victim_addr = {TAG_RSP.entry.ptag, 8'h00};

   // ***************************************************
   // sequencer
   // ***************************************************
   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         state_q <= ST_IDLE;
         sel_q <= SEL_PRI_INSTR;
         op_q <= OP_INDEX_INV;
         ea_q <= 32'h00000000;
         caddr_q <= 32'h00000000;
         way_q <= 4'h0;
         index_q <= 16'h0000;
         new_q <= '0;
         fill_after_wb_q <= 1'b0;
         exc_q <= EXC_NONE;
      end
      else if (CLK_EN)
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (take)
               begin
                  sel_q <= sel_d;
                  op_q <= op_d;
                  ea_q <= ea_d;
                  caddr_q <= ea_d;
                  way_q <= way_of(ea_d);
                  index_q <= index_of(ea_d);
                  exc_q <= EXC_NONE;
                  fill_after_wb_q <= 1'b0;
                  if (!COP0_USABLE)
                  begin
                     exc_q <= EXC_COP_UNUSABLE;
                     state_q <= ST_FINISH;
                  end
                  else if (ctl_q[CTL_KCHK_BIT] && !KERNEL_MODE
                           && ea_d[KSEG_BIT])
                  begin
                     exc_q <= EXC_ADDR_LOAD;
                     state_q <= ST_FINISH;
                  end
                  else if (!ctl_q[CTL_PRESENT_LSB + 32'(sel_d)]
                           || op_d == OP_IMPL_DEF)
                  begin
                     state_q <= ST_FINISH;
                  end
                  else if (addr_op_d && virt_d
                           && !ctl_q[CTL_XLATE_VIRT_BIT])
                  begin
                     state_q <= ST_TAG;
                  end
                  else if (!addr_op_d && !ctl_q[CTL_XLATE_INDEX_BIT])
                  begin
                     state_q <= ST_TAG;
                  end
                  else
                  begin
                     state_q <= ST_XLATE;
                  end
               end
            end
            ST_XLATE:
            begin
               if (MMU_ACK && (MMU_MISS || MMU_INVALID))
               begin
                  // both faults carry the load cause
                  exc_q <= MMU_MISS ? EXC_TLB_REFILL
                                    : EXC_TLB_INVALID;
                  state_q <= ST_FINISH;
               end
               else if (MMU_ACK)
               begin
                  // virtual caches keep the effective address for address ops (op bit 2)
                  if (!(op_q[2] && ctl_q[CTL_VIRT_LSB + 32'(sel_q)]))
                  begin
                     caddr_q <= MMU_PADDR;
                     way_q <= way_of(MMU_PADDR);
                     index_q <= index_of(MMU_PADDR);
                  end
                  state_q <= ST_TAG;
               end
            end
            ST_TAG:
            begin
               if (TAG_ACK)
               begin
                  if (op_q[2])
                  begin
                     way_q <= TAG_RSP.way;
                  end
                  new_q <= TAG_RSP.entry;
                  new_q.valid <= 1'b0;
                  state_q <= ST_UPDATE;
                  case (op_q)
                     OP_INDEX_INV, OP_HIT_INV, OP_HIT_WB_INV:
                     begin
                        if (op_q[2] && !hit)
                        begin
                           state_q <= ST_FINISH;
                        end
                     end
                     OP_HIT_WB:
                     begin
                        new_q.valid <= 1'b1;
                        new_q.dirty <= 1'b0;
                        if (!(hit && dirty_line))
                        begin
                           state_q <= ST_FINISH;
                        end
                     end
                     OP_FETCH_LOCK:
                     begin
                        new_q.valid <= 1'b1;
                        new_q.lock <= 1'b1;
                        if (!hit)
                        begin
                           new_q.ptag <= caddr_q[31:PTAG_LSB];
                           new_q.dirty <= 1'b0;
                           fill_after_wb_q <= 1'b1;
                           state_q <= ST_FILL;
                        end
                     end
                     default:
                     begin
                        state_q <= ST_FINISH;
                     end
                  endcase
                  // an unreadable victim leaves the line untouched
                  if (wb_go && TAG_RSP.cache_err)
                  begin
                     exc_q <= EXC_CACHE_ERR;
                     state_q <= ST_FINISH;
                  end
                  else if (wb_go)
                  begin
                     state_q <= ST_WBACK;
                  end
               end
            end
            ST_WBACK, ST_FILL:
            begin
               if (MEM_ACK && MEM_ERR)
               begin
                  // failed writeback is a cache error, failed fill a bus one
                  exc_q <= state_q == ST_WBACK ? EXC_CACHE_ERR
                                               : EXC_BUS_ERR;
                  state_q <= ST_FINISH;
               end
               else if (MEM_ACK)
               begin
                  state_q <= state_q == ST_WBACK && fill_after_wb_q
                             ? ST_FILL : ST_UPDATE;
               end
            end
            ST_UPDATE:
            begin
               if (TAG_ACK)
               begin
                  state_q <= ST_FINISH;
               end
            end
            ST_FINISH:
            begin
               state_q <= ST_IDLE;
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign load_tag_done = CLK_EN && state_q == ST_TAG && TAG_ACK
                          && op_q == OP_LOAD_TAG;

   // ***************************************************
   // port flops
   // ***************************************************
   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         ISSUE_READY <= 1'b0;
         DONE <= 1'b0;
         EXC_KIND <= EXC_NONE;
         EXC_LOAD_CAUSE <= 1'b0;
      end
      else if (CLK_EN)
      begin
         ISSUE_READY <= (state_q == ST_IDLE && !take)
                        || state_q == ST_FINISH;
         DONE <= state_q == ST_FINISH;
         EXC_KIND <= state_q == ST_FINISH ? exc_q : EXC_NONE;
         EXC_LOAD_CAUSE <= state_q == ST_FINISH
                           && (exc_q == EXC_TLB_REFILL
                           || exc_q == EXC_TLB_INVALID
                           || exc_q == EXC_ADDR_LOAD);
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         MMU_REQ <= 1'b0;
         MMU_VADDR <= 32'h00000000;
      end
      else if (CLK_EN)
      begin
         MMU_REQ <= state_q == ST_XLATE && !MMU_ACK;
         MMU_VADDR <= ea_q;
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         TAG_REQ <= 1'b0;
         TAG_CMD <= '0;
      end
      else if (CLK_EN)
      begin
         TAG_REQ <= (state_q == ST_TAG || state_q == ST_UPDATE)
                    && !TAG_ACK;
         TAG_CMD.sel <= sel_q;
         TAG_CMD.way <= way_q;
         TAG_CMD.index <= index_q;
         TAG_CMD.addr <= caddr_q;
         if (state_q == ST_UPDATE)
         begin
            TAG_CMD.cmd <= TC_WRITE;
            TAG_CMD.entry <= new_q;
         end
         else if (op_q == OP_STORE_TAG)
         begin
            TAG_CMD.cmd <= TC_WRITE;
            TAG_CMD.entry <= {tag_high_q, tag_low_q};
         end
         else
         begin
            TAG_CMD.cmd <= op_q[2] ? TC_LOOKUP : TC_READ;
            TAG_CMD.entry <= '0;
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         MEM_REQ <= 1'b0;
         MEM_WR <= 1'b0;
         MEM_ADDR <= 32'h00000000;
      end
      else if (CLK_EN)
      begin
         MEM_REQ <= (state_q == ST_WBACK || state_q == ST_FILL)
                    && !MEM_ACK;
         MEM_WR <= state_q == ST_WBACK;
         if (state_q == ST_TAG && TAG_ACK)
         begin
            // writeback goes to the address held in the tag
            MEM_ADDR <= victim_addr;
         end
         else if (state_q == ST_FILL)
         begin
            MEM_ADDR <= {caddr_q[31:PTAG_LSB], 8'h00};
         end
      end
   end

   // ***************************************************
   // holding and control registers
   // ***************************************************
   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         tag_low_q <= HOLD_RESET;
         tag_high_q <= HOLD_RESET;
         data_low_q <= HOLD_RESET;
         data_high_q <= HOLD_RESET;
      end
      else if (load_tag_done)
      begin
         tag_low_q <= TAG_RSP.entry[31:0];
         tag_high_q <= TAG_RSP.entry.hi;
         data_low_q <= TAG_RSP.data[31:0];
         data_high_q <= TAG_RSP.data[63:32];
      end
      else if (CLK_EN && REG_WR)
      begin
         case (REG_ADDR)
            REG_TAG_LOW: tag_low_q <= REG_WDATA;
            REG_TAG_HIGH: tag_high_q <= REG_WDATA;
            REG_DATA_LOW: data_low_q <= REG_WDATA;
            REG_DATA_HIGH: data_high_q <= REG_WDATA;
            default: ;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         ctl_q <= CTL_RESET;
      end
      else if (CLK_EN && REG_WR && REG_ADDR == REG_CONTROL)
      begin
         ctl_q <= {17'h00000, REG_WDATA[14:0]};
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         REG_RDATA <= 32'h00000000;
      end
      else if (CLK_EN)
      begin
         REG_RDATA <= 32'h00000000;
         if (REG_RD)
         begin
            case (REG_ADDR)
               REG_TAG_LOW: REG_RDATA <= tag_low_q;
               REG_TAG_HIGH: REG_RDATA <= tag_high_q;
               REG_DATA_LOW: REG_RDATA <= data_low_q;
               REG_DATA_HIGH: REG_RDATA <= data_high_q;
               REG_CONTROL: REG_RDATA <= ctl_q;
               REG_STATUS: REG_RDATA <= {20'h00000, op_q, sel_q,
                  state_q != ST_IDLE, state_q, exc_q};
               default: REG_RDATA <= 32'h00000000;
            endcase
         end
      end
   end
endmodule : cache_maint_unit
`default_nettype wire

// ==== cache_maintenance_op_unit_tb_top.sv ====
// self-checking bench for the cache maintenance unit
`default_nettype none
module cache_maintenance_op_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cache_op_pkg::*;
   logic clk = 1'b0, rst = 1'b1, vld = 1'b0, cop = 1'b1, kern = 1'b1;
   logic miss_i = 1'b0, err_i = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [31:0] instr = 32'h0, base = 32'h0, wdata = 32'h0;
   logic [7:0] addr = 8'h0;
   logic [3:0] lat = 4'h0;
   tag_rsp_t rsp_i = '0;
   tag_rsp_t rsp;
   tag_req_t tcmd, tag_seen;
   exc_kind_t exc;
   logic ready, done, lcause, mreq, mack, miss, inval, treq, tack;
   logic memreq, memwr, memack, err, wr_seen;
   logic [31:0] rdata, vaddr, paddr, maddr, mem_seen;
   int errors = 0, checks = 0, cyc = 0, treqs = 0, memn = 0, n = 0;
   cache_maint_unit i_dut (.SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1),
      .ISSUE_VALID(vld), .ISSUE_INSTR(instr), .ISSUE_BASE(base),
      .COP0_USABLE(cop), .KERNEL_MODE(kern), .ISSUE_READY(ready),
      .DONE(done), .EXC_KIND(exc), .EXC_LOAD_CAUSE(lcause), .MMU_REQ(mreq),
      .MMU_VADDR(vaddr), .MMU_ACK(mack), .MMU_PADDR(paddr), .MMU_MISS(miss),
      .MMU_INVALID(inval), .TAG_REQ(treq), .TAG_CMD(tcmd), .TAG_ACK(tack),
      .TAG_RSP(rsp), .MEM_REQ(memreq), .MEM_WR(memwr), .MEM_ADDR(maddr),
      .MEM_ACK(memack), .MEM_ERR(err), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
   cache_far_side i_far (.clk, .rst, .lat, .mmu_req(mreq), .vaddr, .miss_i,
      .mmu_ack(mack), .paddr, .miss, .inval, .tag_req(treq), .rsp_i,
      .tag_ack(tack), .rsp, .mem_req(memreq), .err_i, .mem_ack(memack),
      .err);
   always #2.5 clk = ~clk;
   // *********
   // tasks
   // *********
   task automatic chk(input logic [63:0] seen, exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, logic [31:0] e, string w);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e, w);
   endtask : reg_rd
   task automatic issue(input cache_sel_t s, cache_op_t o,
      logic [31:0] b, logic [15:0] off, exc_kind_t e);
      int k;
      @(posedge clk);
      instr <= {11'h0, o, s, off};
      base <= b;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      #1 k = 0;
      while (done !== 1'b1 && k < 300)
      begin
         @(posedge clk);
         #1 k++;
      end
      chk(done, 1'b1, "done");
      chk(exc, e, "exception");
   endtask : issue
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (treq && tack)
         tag_seen <= tcmd;
      treqs <= treqs + (treq && tack);
      memn <= memn + (memreq && memack);
      if (memreq && memack)
         {mem_seen, wr_seen} <= {maddr, memwr};
      if (cyc == 20000)
      begin
         errors++;
         conclude();
      end
   end
   // *********
   // sequence
   // *********
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      reg_rd(REG_CONTROL, CTL_RESET, "control");
      reg_rd(8'h20, 32'h0, "unmapped");
      reg_rd(REG_TAG_LOW, HOLD_RESET, "tag low");
      cop <= 1'b0;
      issue(SEL_PRI_DATA, OP_HIT_INV, 32'h0, 16'h0, EXC_COP_UNUSABLE);
      cop <= 1'b1;
      rsp_i <= {1'b1, 4'h0, 1'b1, 32'ha5, 32'h123456e0, 64'h0};
      issue(SEL_PRI_DATA, OP_LOAD_TAG, 32'h6001, 16'hfffb, EXC_NONE);
      chk(tag_seen.addr, 32'h5ffc, "address");
      chk(tag_seen.way, 4'h2, "way");
      chk(tag_seen.index, 16'h00ff, "set");
      reg_rd(REG_TAG_LOW, 32'h123456e0, "tag low");
      reg_rd(REG_TAG_HIGH, 32'ha5, "tag high");
      reg_wr(REG_TAG_LOW, 32'h00abcd80);
      reg_wr(REG_TAG_HIGH, 32'h5);
      issue(SEL_PRI_INSTR, OP_STORE_TAG, 32'h0, 16'h40, EXC_NONE);
      chk(tag_seen.entry, {32'h5, 32'h00abcd80}, "stored tag");
      lat <= 4'h3;
      rsp_i <= {1'b1, 4'h1, 1'b0, 32'h0, 32'h000a0bc0, 64'h0};
      issue(SEL_PRI_DATA, OP_INDEX_INV, 32'h0, 16'h100, EXC_NONE);
      chk(mem_seen, 32'h000a0b00, "writeback address");
      chk(wr_seen, 1'b1, "writeback");
      chk(tag_seen.entry.valid, 1'b0, "valid");
      n = memn;
      issue(SEL_PRI_INSTR, OP_INDEX_INV, 32'h0, 16'h100, EXC_NONE);
      chk(memn, n, "transfers");
      chk(tag_seen.entry.valid, 1'b0, "valid");
      issue(SEL_PRI_DATA, OP_HIT_WB, 32'h0a0b00, 16'h0, EXC_NONE);
      chk({tag_seen.entry.valid, tag_seen.entry.dirty}, 2'b10, "clean");
      issue(SEL_PRI_DATA, OP_HIT_WB_INV, 32'h0a0b00, 16'h0, EXC_NONE);
      chk(tag_seen.entry.valid, 1'b0, "valid");
      err_i <= 1'b1;
      issue(SEL_PRI_DATA, OP_INDEX_INV, 32'h0, 16'h0, EXC_CACHE_ERR);
      rsp_i <= {1'b0, 4'h2, 1'b0, 32'h0, 32'h0, 64'h0};
      issue(SEL_PRI_DATA, OP_FETCH_LOCK, 32'h4567, 16'h0, EXC_BUS_ERR);
      chk({mem_seen, wr_seen}, {32'h4500, 1'b0}, "fill");
      err_i <= 1'b0;
      miss_i <= 1'b1;
      issue(SEL_PRI_DATA, OP_HIT_INV, 32'h1000, 16'h0, EXC_TLB_REFILL);
      miss_i <= 1'b0;
      kern <= 1'b0;
      issue(SEL_PRI_DATA, OP_HIT_INV, 32'h80000000, 16'h0, EXC_ADDR_LOAD);
      kern <= 1'b1;
      n = treqs;
      for (int s = 0; s < 4; s++)
         issue(cache_sel_t'(s), OP_IMPL_DEF, 32'h0, 16'h0, EXC_NONE);
      chk(treqs, n, "tag requests");
      conclude();
   end
endmodule : cache_maintenance_op_unit_tb_top
`default_nettype wire

// ==== cache_op_pkg.sv ====
// constants, types and register map of the cache maintenance unit
//
// What this block does
// - address is base plus sign-extended 16-bit offset
// - virtual cache: effective address addresses cache for address ops
// - physical cache: translated address addresses cache, for index ops only with CTL_XLATE_INDEX_BIT set
// - index ops take way and set from address
// - direct-mapped cache ignores the way field
// - translation faults carry the load cause
// - never modified fault nor store cause
// - any byte alignment, no alignment fault
// - writeback cache or bus error: cache error
// - failed fill bus transfer raises bus error
// - protected kernel region may raise address error
// - bits 17:16 select the target cache
// - bits 20:18 select the operation
// - index invalidate on instruction cache clears block
// - dirty write-back block written back, then invalidated
// - write-through index invalidate skips writeback
// - load tag fills holding registers, no error
// - store tag writes tag from holding registers, no error
// - operation three is implementation defined
// - hit invalidate only on matching block
// - hit writeback invalidate writes back, invalidates
// - hit writeback cleans dirty block, stays valid
// - fetch and lock fills if missing, locks
// - unusable coprocessor raises unusable fault
`default_nettype none
package cache_op_pkg;
   // ***************************************************
   // instruction fields
   // ***************************************************
   localparam int OFFSET_LSB = 0;
   localparam int OFFSET_W = 16;
   localparam int SEL_LSB = 16;
   localparam int OP_LSB = 18;

   typedef enum logic [1:0] {
      SEL_PRI_INSTR = 2'h0,
      SEL_PRI_DATA = 2'h1,
      SEL_TERTIARY = 2'h2,
      SEL_SECONDARY = 2'h3
   } cache_sel_t;

   typedef enum logic [2:0] {
      OP_INDEX_INV = 3'h0,
      OP_LOAD_TAG = 3'h1,
      OP_STORE_TAG = 3'h2,
      OP_IMPL_DEF = 3'h3,
      OP_HIT_INV = 3'h4,
      OP_HIT_WB_INV = 3'h5,
      OP_HIT_WB = 3'h6,
      OP_FETCH_LOCK = 3'h7
   } cache_op_t;

   typedef enum logic [2:0] {
      EXC_NONE = 3'h0,
      EXC_COP_UNUSABLE = 3'h1,
      EXC_ADDR_LOAD = 3'h2,
      EXC_TLB_REFILL = 3'h3,
      EXC_TLB_INVALID = 3'h4,
      EXC_CACHE_ERR = 3'h5,
      EXC_BUS_ERR = 3'h6
   } exc_kind_t;

   // ***************************************************
   // tag array port
   // ***************************************************
   typedef enum logic [1:0] {
      TC_READ = 2'h0,
      TC_LOOKUP = 2'h1,
      TC_WRITE = 2'h2
   } tag_cmd_t;

   // low word layout is the tag low holding register layout
   typedef struct packed {
      logic [31:0] hi;
      logic [23:0] ptag;
      logic valid;
      logic dirty;
      logic lock;
      logic [4:0] rsvd;
   } tag_entry_t;

   typedef struct packed {
      tag_cmd_t cmd;
      cache_sel_t sel;
      logic [3:0] way;
      logic [15:0] index;
      logic [31:0] addr;
      tag_entry_t entry;
   } tag_req_t;

   typedef struct packed {
      logic hit;
      logic [3:0] way;
      logic cache_err;
      tag_entry_t entry;
      logic [63:0] data;
   } tag_rsp_t;

   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [7:0] REG_TAG_LOW = 8'h00;
   localparam logic [7:0] REG_TAG_HIGH = 8'h04;
   localparam logic [7:0] REG_DATA_LOW = 8'h08;
   localparam logic [7:0] REG_DATA_HIGH = 8'h0c;
   localparam logic [7:0] REG_CONTROL = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;

   localparam int CTL_PRESENT_LSB = 0;
   localparam int CTL_WBACK_LSB = 4;
   localparam int CTL_VIRT_LSB = 8;
   localparam int CTL_KCHK_BIT = 12;
   localparam int CTL_XLATE_VIRT_BIT = 13;
   localparam int CTL_XLATE_INDEX_BIT = 14;
   localparam logic [31:0] CTL_RESET = 32'h000010ef;
   localparam logic [31:0] HOLD_RESET = 32'h00000000;
   localparam int KSEG_BIT = 31;
   localparam int PTAG_LSB = 8;
endpackage : cache_op_pkg
`default_nettype wire
